// ---- logic/mtg_map.vh ----
// constants for the measurement time gate: register map, fields, timing
// assumes a 32-bit ahb-lite slave and a 10 MHz system clock
`ifndef MTG_MAP_VH
`define MTG_MAP_VH

// register byte offsets
`define MTG_CTRL_OFF 12'h000
`define MTG_DELAY_OFF 12'h004
`define MTG_GATE_OFF 12'h008
`define MTG_HOLD_OFF 12'h00c
`define MTG_STAT_OFF 12'h010

// control fields
`define MTG_CTRL_MODE_LSB 0
`define MTG_CTRL_MODE_MSB 1
`define MTG_CTRL_POL_BIT 2
`define MTG_CTRL_CHAN_BIT 3

// mode encodings
`define MTG_MODE_OFF 2'h0
`define MTG_MODE_LEVEL 2'h1
`define MTG_MODE_EDGE 2'h2

// reset values
`define MTG_CTRL_RST 4'h0
`define MTG_DELAY_RST 16'h0000
`define MTG_GATE_RST 16'h0001
`define MTG_HOLD_RST 16'h0000

// timing: one timer step in ns, system clock period in ns
`define MTG_STEP_NS 5000
`define MTG_CLK_NS 100
`define MTG_TICK_CYC (`MTG_STEP_NS / `MTG_CLK_NS)

// sequencer states
`define MTG_ST_IDLE 2'h0
`define MTG_ST_DELAY 2'h1
`define MTG_ST_GATE 2'h2
`define MTG_ST_HOLD 2'h3

`endif

// ---- logic/mtg_tick.v ----
// 5 us step tick generator for the gate timers
// assumes hclk at the rate given in mtg_map.vh
`timescale 1ns/1ps
`include "mtg_map.vh"

module mtg_tick #(
    parameter CYC = `MTG_TICK_CYC
) (
    input wire hclk,
    input wire hresetn,
    input wire restart,
    output reg tick
);

localparam integer LAST_I = CYC - 1;
// the step count fits eight bits at the documented clock rate
localparam [7:0] LAST = LAST_I[7:0];

reg [7:0] cnt_q;

// restart realigns the step so a sequence starts on a full step
always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        cnt_q <= 8'h00;
        tick <= 1'b0;
    end else if (restart) begin
        cnt_q <= 8'h00;
        tick <= 1'b0;
    end else if (cnt_q == LAST) begin
        cnt_q <= 8'h00;
        tick <= 1'b1; // RL9 RL16
    end else begin
        cnt_q <= cnt_q + 8'h01;
        tick <= 1'b0;
    end
end

endmodule

// ---- logic/mtg_sync.v ----
// two-stage synchroniser with edge detection for the trigger input
// assumes the trigger is asynchronous TTL from the rear connector
`timescale 1ns/1ps

module mtg_sync (
    input wire hclk,
    input wire hresetn,
    input wire din,
    output wire level,
    output wire rise,
    output wire fall
);

reg s1_q;
reg s2_q;
reg s3_q;

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        s1_q <= 1'b0;
        s2_q <= 1'b0;
        s3_q <= 1'b0;
    end else begin
        s1_q <= din;
        s2_q <= s1_q;
        s3_q <= s2_q;
    end
end

// only the second and third stages are looked at
assign level = s2_q; // RL16
assign rise = s2_q & ~s3_q;
assign fall = ~s2_q & s3_q;

endmodule

// ---- logic/mtg_gate.v ----
// measurement time gate: ahb-lite register slave and gate sequencer
// assumes one trigger input, two sensor channels, 10 MHz hclk
`timescale 1ns/1ps
`include "mtg_map.vh"

// Functional notes
// RL1 - mode is off, level-gated or edge-triggered; latest write governs
// RL2 - off mode keeps both gate outputs closed, no trigger restriction
// RL3 - level mode: gate open exactly while trigger is at active level
// RL4 - level mode: polarity bit picks high or low as active level
// RL5 - edge mode: polarity bit picks rising or falling edge
// RL6 - edge mode: programmable delay from edge to gate open
// RL7 - gate stays open for programmed duration, minimum one step
// RL8 - programmable holdoff runs after gate closes
// RL9 - delay, gate and holdoff counted in 5 us steps
// RL10 - accepted edge starts delay; no gate before delay elapses
// RL11 - delay expiry opens gate at once, closes after duration
// RL12 - edges during delay, gate and holdoff are ignored
// RL13 - times accurate to 1.5 us or 100 ppm of set value; the delay runs value+1 steps, one 5 us step over its set value
// RL14 - channel bit routes gate to sensor A or B only
// RL15 - zero delay gives shortest nonzero hardware delay
// RL16 - 16-bit down-counters on 5 us tick; trigger synchronised
// RL17 - mode or polarity change aborts sequence, gate closed
module mtg_gate #(
    parameter TW = 16
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    output reg [31:0] hrdata,
    output wire hreadyout,
    output wire hresp,
    input wire trig_in,
    output reg gate_a,
    output reg gate_b,
    output wire gate_busy
);

////////////////////////////////////////////////////////////////////////////////
// register slave

reg [3:0] ctrl_q;
reg [TW-1:0] delay_q;
reg [TW-1:0] gate_q;
reg [TW-1:0] hold_q;
reg wr_pend_q;
reg [11:0] wr_addr_q;
reg [1:0] state_q;
reg [1:0] state_d;
reg [TW-1:0] cnt_q;
reg [TW-1:0] cnt_d;

wire addr_ph = hsel & hready & htrans[1];
wire [1:0] mode = ctrl_q[`MTG_CTRL_MODE_MSB:`MTG_CTRL_MODE_LSB];
wire pol = ctrl_q[`MTG_CTRL_POL_BIT];
wire chan = ctrl_q[`MTG_CTRL_CHAN_BIT];

// single-cycle answers, never an error
assign hreadyout = 1'b1;
assign hresp = 1'b0;

function [31:0] rd_mux;
    input [11:0] a;
    begin
        case (a)
            `MTG_CTRL_OFF: rd_mux = {28'h0000000, ctrl_q};
            `MTG_DELAY_OFF: rd_mux = {16'h0000, delay_q};
            `MTG_GATE_OFF: rd_mux = {16'h0000, gate_q};
            `MTG_HOLD_OFF: rd_mux = {16'h0000, hold_q};
            `MTG_STAT_OFF: rd_mux = {12'h000, gate_b, gate_a, state_q, cnt_q};
            default: rd_mux = 32'h00000000;
        endcase
    end
endfunction

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        wr_pend_q <= 1'b0;
        wr_addr_q <= 12'h000;
        hrdata <= 32'h00000000;
    end else begin
        wr_pend_q <= addr_ph & hwrite;
        if (addr_ph) begin
            wr_addr_q <= haddr[11:0];
        end
        if (addr_ph & ~hwrite) begin
            hrdata <= rd_mux(haddr[11:0]);
        end
    end
end

// a write of ctrl that alters mode or polarity aborts the sequence
wire ctrl_wr = wr_pend_q & (wr_addr_q == `MTG_CTRL_OFF);
wire abort = ctrl_wr & (hwdata[`MTG_CTRL_POL_BIT:`MTG_CTRL_MODE_LSB] != ctrl_q[2:0]); // RL17

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        ctrl_q <= `MTG_CTRL_RST;
        delay_q <= `MTG_DELAY_RST;
        gate_q <= `MTG_GATE_RST;
        hold_q <= `MTG_HOLD_RST;
    end else if (wr_pend_q) begin
        case (wr_addr_q)
            `MTG_CTRL_OFF: ctrl_q <= hwdata[3:0]; // RL1 RL14
            `MTG_DELAY_OFF: delay_q <= hwdata[TW-1:0]; // RL6
            // a zero duration is raised to the one-step minimum
            `MTG_GATE_OFF: gate_q <= (hwdata[TW-1:0] == {TW{1'b0}}) ?
                {{(TW-1){1'b0}}, 1'b1} : hwdata[TW-1:0]; // RL7
            `MTG_HOLD_OFF: hold_q <= hwdata[TW-1:0]; // RL8
            default: ;
        endcase
    end
end

////////////////////////////////////////////////////////////////////////////////
// trigger conditioning and step tick

wire trig_lvl;
wire trig_rise;
wire trig_fall;
wire tick;

mtg_sync u_sync (
    .hclk(hclk),
    .hresetn(hresetn),
    .din(trig_in),
    .level(trig_lvl),
    .rise(trig_rise),
    .fall(trig_fall)
);

wire edge_hit = pol ? trig_fall : trig_rise; // RL5
wire start = (mode == `MTG_MODE_EDGE) & (state_q == `MTG_ST_IDLE) & edge_hit & ~abort;

// tick realigns on each accepted edge so step error stays under one clock (100 ns)
mtg_tick u_tick (
    .hclk(hclk),
    .hresetn(hresetn),
    .restart(start),
    .tick(tick)
); // RL13

////////////////////////////////////////////////////////////////////////////////
// edge-mode sequencer

wire cnt_zero = (cnt_q == {TW{1'b0}});

always @* begin
    state_d = state_q;
    cnt_d = cnt_q;
    case (state_q)
        `MTG_ST_IDLE: begin
            if (start) begin
                // delay counts value+1 steps, so zero still takes one step
                state_d = `MTG_ST_DELAY; // RL10 RL15
                cnt_d = delay_q;
            end
        end
        `MTG_ST_DELAY: begin
            if (tick) begin
                if (cnt_zero) begin
                    state_d = `MTG_ST_GATE; // RL11
                    cnt_d = gate_q - {{(TW-1){1'b0}}, 1'b1};
                end else begin
                    cnt_d = cnt_q - {{(TW-1){1'b0}}, 1'b1}; // RL16
                end
            end
        end
        `MTG_ST_GATE: begin
            if (tick) begin
                if (cnt_zero) begin
                    if (hold_q == {TW{1'b0}}) begin
                        state_d = `MTG_ST_IDLE;
                    end else begin
                        state_d = `MTG_ST_HOLD; // RL8
                        cnt_d = hold_q - {{(TW-1){1'b0}}, 1'b1};
                    end
                end else begin
                    cnt_d = cnt_q - {{(TW-1){1'b0}}, 1'b1};
                end
            end
        end
        `MTG_ST_HOLD: begin
            // edges are never looked at outside idle
            if (tick) begin
                if (cnt_zero) begin
                    state_d = `MTG_ST_IDLE; // RL12
                end else begin
                    cnt_d = cnt_q - {{(TW-1){1'b0}}, 1'b1};
                end
            end
        end
        default: begin
            state_d = `MTG_ST_IDLE;
        end
    endcase
    if (abort || mode != `MTG_MODE_EDGE) begin
        state_d = `MTG_ST_IDLE; // RL17
        cnt_d = {TW{1'b0}};
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        state_q <= `MTG_ST_IDLE;
        cnt_q <= {TW{1'b0}};
    end else begin
        state_q <= state_d;
        cnt_q <= cnt_d;
    end
end

////////////////////////////////////////////////////////////////////////////////
// gate output

reg gate_d;

always @* begin
    case (mode)
        `MTG_MODE_LEVEL: gate_d = trig_lvl ^ pol; // RL3 RL4
        `MTG_MODE_EDGE: gate_d = (state_d == `MTG_ST_GATE); // RL11
        default: gate_d = 1'b0; // RL2
    endcase
    if (abort) begin
        gate_d = 1'b0;
    end
end

always @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
        gate_a <= 1'b0;
        gate_b <= 1'b0;
    end else begin
        gate_a <= gate_d & ~chan; // RL14
        gate_b <= gate_d & chan;
    end
end

assign gate_busy = (state_q != `MTG_ST_IDLE);

endmodule

// ---- test/mtg_gate_chk.sv ----
// checker for the time gate: bus answers, gate routing and edge sequence timing
// assumes a 10 MHz hclk and a 50-clock timer step
`timescale 1ns/1ps
module mtg_gate_chk #(
    parameter TW = 16
) (
    input wire hclk,
    input wire hresetn,
    input wire hsel,
    input wire [31:0] haddr,
    input wire [1:0] htrans,
    input wire hwrite,
    input wire [2:0] hsize,
    input wire [31:0] hwdata,
    input wire hready,
    input wire [31:0] hrdata,
    input wire hreadyout,
    input wire hresp,
    input wire trig_in,
    input wire gate_a,
    input wire gate_b,
    input wire gate_busy
);
    default clocking @(posedge hclk); endclocking
    default disable iff (!hresetn);
    wire rd_take = hsel && hready && htrans[1] && !hwrite;
    sequence armed;
        $rose(gate_busy);
    endsequence
    sequence opened;
        $rose(gate_a) && gate_busy;
    endsequence
    sequence closed;
        $fell(gate_a) && gate_busy;
    endsequence
    ////////////////////////////////////////////////////////////////////////
    ready_ok_a: assert property (hreadyout && !hresp) else $error("bus answer not okay");
    gates_excl_a: assert property (!(gate_a && gate_b)) else $error("both gates open");
    // the pin moved between the samples three and four clocks before the sequencer armed
    busy_cause_a: assert property (armed |-> $past(trig_in, 3) != $past(trig_in, 4))
        else $error("sequence started without edge");
    busy_closed_a: assert property (armed |-> !gate_a && !gate_b)
        else $error("gate open at sequence start");
    delay_min_a: assert property (opened |-> $past(gate_busy, 45))
        else $error("delay shorter than one step");
    gate_min_a: assert property (closed |-> $past(gate_a, 45))
        else $error("gate shorter than one step");
    hold_closed_a: assert property (closed |=> !gate_a [*4]) else $error("gate reopened");
    rdata_hold_a: assert property (!$past(rd_take) |-> $stable(hrdata))
        else $error("read data moved");
endmodule
bind mtg_gate mtg_gate_chk #(.TW(TW)) u_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .trig_in(trig_in), .gate_a(gate_a), .gate_b(gate_b), .gate_busy(gate_busy));

// ---- test/mtg_trig_src.sv ----
// rear trigger source: a pulse of width clocks on fire, inv flips the idle level
// assumes fire is a one-cycle strobe from the bench
`timescale 1ns/1ps
module mtg_trig_src (
    input wire hclk,
    input wire fire,
    input wire inv,
    input wire [7:0] width,
    output reg trig_in
);
    reg [7:0] left_q = 8'h0;
    always @(posedge hclk) begin
        if (fire)
            left_q <= width;
        else if (left_q != 8'h0)
            left_q <= left_q - 8'h1;
    end
    always @* trig_in = inv ^ (left_q != 8'h0);
endmodule

// ---- test/tb_top.sv ----
// bench for the time gate: registers, off, level and edge modes, abort
// assumes the trigger source model and the checker bound to the design
`timescale 1ns/1ps
`include "mtg_map.vh"
module tb_top;
    reg hclk = 1'b0;
    reg hresetn = 1'b0;
    reg hsel = 1'b0;
    reg hwrite = 1'b0;
    reg fire = 1'b0;
    reg inv = 1'b0;
    reg [31:0] haddr = 32'h0;
    reg [31:0] hwdata = 32'h0;
    reg [1:0] htrans = 2'h0;
    reg [2:0] hsize = 3'h2;
    reg [7:0] width = 8'h0;
    wire [31:0] hrdata;
    wire hreadyout, hresp, trig_in, gate_a, gate_b, gate_busy;
    integer n_errors = 0;
    integer compares = 0;
    integer n;
    reg [31:0] rd;
    always #50 hclk = ~hclk;
    mtg_gate #(.TW(16)) dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .trig_in(trig_in), .gate_a(gate_a), .gate_b(gate_b), .gate_busy(gate_busy));
    mtg_trig_src src (.hclk(hclk), .fire(fire), .inv(inv), .width(width), .trig_in(trig_in));
    ////////////////////////////////////////////////////////////////////////
    task chk(input [31:0] got, input [31:0] exp);
        begin
            compares = compares + 1;
            if (got !== exp) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
            end
        end
    endtask
    task chk_rng(input integer got, input integer lo, input integer hi);
        begin
            compares = compares + 1;
            if (got < lo || got > hi) begin
                n_errors = n_errors + 1;
                $display("CHECK FAILED t=%0t got=%h exp=%h..%h", $time, got, lo, hi);
            end
        end
    endtask
    // hready is waited on rather than assumed, even though the slave never stalls
    task ahb(input w, input [11:0] a, input [31:0] d);
        begin
            @(posedge hclk);
            hsel <= 1'b1;
            htrans <= 2'h2;
            hwrite <= w;
            haddr <= {20'h0, a};
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            hsel <= 1'b0;
            htrans <= 2'h0;
            hwdata <= d;
            @(posedge hclk);
            while (hreadyout !== 1'b1) @(posedge hclk);
            rd = hrdata;
        end
    endtask
    task pulse(input [7:0] w);
        begin
            @(posedge hclk);
            fire <= 1'b1;
            width <= w;
            @(posedge hclk);
            fire <= 1'b0;
        end
    endtask
    task wt(input [1:0] s, input v);
        begin
            n = 0;
            while ((s == 0 ? gate_a : s == 1 ? gate_b : gate_busy) !== v && n < 2000) begin
                @(posedge hclk);
                n = n + 1;
            end
        end
    endtask
    ////////////////////////////////////////////////////////////////////////
    task t_regs;
        begin
            ahb(0, `MTG_CTRL_OFF, 0); chk(rd, 32'h0);
            ahb(0, `MTG_DELAY_OFF, 0); chk(rd, 32'h0);
            ahb(0, `MTG_GATE_OFF, 0); chk(rd, 32'h1);
            ahb(0, `MTG_HOLD_OFF, 0); chk(rd, 32'h0);
            ahb(0, 12'h020, 0); chk(rd, 32'h0);
            ahb(1, `MTG_GATE_OFF, 32'h0);
            ahb(0, `MTG_GATE_OFF, 0); chk(rd, 32'h1);
            ahb(1, `MTG_DELAY_OFF, 32'hffff);
            ahb(0, `MTG_DELAY_OFF, 0); chk(rd, 32'hffff);
            $display("t_regs done");
        end
    endtask
    task t_off;
        begin
            pulse(20);
            wt(2, 1); chk_rng(n, 40, 2000);
            chk({gate_a, gate_b}, 32'h0);
            $display("t_off done");
        end
    endtask
    task t_level(input p);
        begin
            inv <= p;
            repeat (5) @(posedge hclk);
            ahb(1, `MTG_CTRL_OFF, {28'h0, 1'b1, p, 2'h1});
            repeat (10) @(posedge hclk);
            chk({gate_a, gate_b}, 32'h0);
            pulse(40);
            wt(1, 1); chk_rng(n, 1, 6);
            wt(1, 0); chk_rng(n, 37, 42);
            $display("t_level done");
        end
    endtask
    task t_edge;
        begin
            inv <= 1'b0;
            ahb(1, `MTG_DELAY_OFF, 32'h1);
            ahb(1, `MTG_GATE_OFF, 32'h2);
            ahb(1, `MTG_HOLD_OFF, 32'h2);
            ahb(1, `MTG_CTRL_OFF, 32'h6);
            repeat (10) @(posedge hclk);
            pulse(10);
            wt(2, 1); chk_rng(n, 10, 16);
            wt(0, 1); chk_rng(n, 97, 103);
            wt(0, 0); chk_rng(n, 98, 102);
            pulse(5);
            wt(2, 0); chk_rng(n, 94, 101);
            wt(2, 1); chk_rng(n, 30, 2000);
            $display("t_edge done");
        end
    endtask
    task t_abort;
        begin
            ahb(1, `MTG_DELAY_OFF, 32'h14);
            pulse(3);
            wt(2, 1);
            ahb(0, `MTG_STAT_OFF, 0); chk(rd & 32'h000f0000, 32'h00010000);
            repeat (10) @(posedge hclk);
            ahb(1, `MTG_CTRL_OFF, 32'h2);
            wt(2, 0); chk_rng(n, 0, 2);
            chk({gate_a, gate_b}, 32'h0);
            $display("t_abort done");
        end
    endtask
    task end_of_test;
        begin
            $display("n_errors=%0d compares=%0d", n_errors, compares);
            if (n_errors == 0 && compares > 0)
                $display("bench passed");
            else
                $display("bench failed");
            $finish;
        end
    endtask
    initial begin
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_regs;
        t_off;
        t_level(1'b0);
        t_level(1'b1);
        t_edge;
        t_abort;
        end_of_test;
    end
    // the whole run is a few thousand clocks; twenty thousand means a hang
    initial begin
        #(100 * 20000);
        n_errors = n_errors + 1;
        end_of_test;
    end
endmodule
